// >>> hdl/sensor_interrupt_router.sv
// interrupt enable, routing, pad config and wake source selection with apb slave
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "irq_router_regs.svh"

// Operation
// - transient wakes sleep only when allowed
// - orientation wakes sleep only when allowed
// - pulse wakes sleep only when allowed
// - fall/motion wakes sleep only when allowed
// - polarity bit: 0 active low, 1 high
// - drive bit: 0 push-pull, 1 open drain
// - disabled source flags cause no pin activity
// - bit 7 enables sleep/wake transition interrupt
// - bit 5 enables transient interrupt
// - bit 4 enables orientation interrupt
// - bit 3 enables pulse interrupt
// - bit 2 enables fall/motion interrupt
// - bit 0 enables sample ready interrupt
// - all enable bits reset to zero
// - route bit 1 pin one, 0 pin two
// - all route bits reset to zero
// - any routed enabled source asserts pin
// - sleep/wake interrupt on each rate transition
module sensor_interrupt_router
   import irq_router_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sleeping,
   input wire logic transient_evt,
   input wire logic orientation_evt,
   input wire logic pulse_evt,
   input wire logic fall_motion_evt,
   input wire logic sample_ready_evt,
   input wire logic irq_pin_one_i,
   input wire logic irq_pin_two_i,
   output logic irq_pin_one_o,
   output logic irq_pin_one_oe_n,
   output logic irq_pin_two_o,
   output logic irq_pin_two_oe_n,
   output logic wake_request,
   output logic [7:0] source_flags
);
   // ----------------------------------------
   // control registers
   // ----------------------------------------
   reg8_t wake_source_and_pin_config_reg;
   reg8_t wake_source_and_pin_config_next;
   reg8_t interrupt_enable_reg;
   reg8_t interrupt_enable_next;
   reg8_t interrupt_pin_routing_reg;
   reg8_t interrupt_pin_routing_next;
   logic [31:0] prdata_next;
   logic pready_next;
   logic pslverr_next;
   logic sel_wake;
   logic sel_en;
   logic sel_route;
   logic sel_src;
   logic access;
   logic commit;

   always_comb
   begin
      access = psel && penable && !pready;
      // a write lands on the edge that completes the transfer, not one before it
      commit = psel && penable && pready && pwrite;
      sel_wake = (paddr == `IDX_TO_ADDR(`WAKE_CFG_IDX));
      sel_en = (paddr == `IDX_TO_ADDR(`IRQ_ENABLE_IDX));
      sel_route = (paddr == `IDX_TO_ADDR(`IRQ_ROUTE_IDX));
      sel_src = (paddr == `IDX_TO_ADDR(`SRC_STATUS_IDX));
      wake_source_and_pin_config_next = wake_source_and_pin_config_reg;
      interrupt_enable_next = interrupt_enable_reg;
      interrupt_pin_routing_next = interrupt_pin_routing_reg;
      prdata_next = `PRDATA_ZERO;
      pready_next = access;
      pslverr_next = 1'b0;
      if (commit)
      begin
         // zero positions are masked so they never hold a one
         if (sel_wake)
         begin
            wake_source_and_pin_config_next = pwdata[7:0] & `WAKE_CFG_MASK;
         end
         if (sel_en)
         begin
            interrupt_enable_next = pwdata[7:0] & `SRC_MASK;
         end
         if (sel_route)
         begin
            interrupt_pin_routing_next = pwdata[7:0] & `SRC_MASK;
         end
      end
      if (access)
      begin
         if (pwrite)
         begin
            pslverr_next = !(sel_wake || sel_en || sel_route);
         end
         else
         begin
            if (sel_wake)
            begin
               prdata_next = {24'h00_0000, wake_source_and_pin_config_reg};
            end
            else if (sel_en)
            begin
               prdata_next = {24'h00_0000, interrupt_enable_reg};
            end
            else if (sel_route)
            begin
               prdata_next = {24'h00_0000, interrupt_pin_routing_reg};
            end
            else if (sel_src)
            begin
               prdata_next = {24'h00_0000, source_flags};
            end
            else
            begin
               pslverr_next = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         wake_source_and_pin_config_reg <= `CFG_RESET;
         interrupt_enable_reg <= `CFG_RESET;
         interrupt_pin_routing_reg <= `CFG_RESET;
         prdata <= `PRDATA_ZERO;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         wake_source_and_pin_config_reg <= wake_source_and_pin_config_next;
         interrupt_enable_reg <= interrupt_enable_next;
         interrupt_pin_routing_reg <= interrupt_pin_routing_next;
         prdata <= prdata_next;
         pready <= pready_next;
         pslverr <= pslverr_next;
      end
   end

   // ----------------------------------------
   // source gating and sleep/wake transition event
   // ----------------------------------------
   logic sleeping_reg;
   logic sleeping_next;
   logic sleep_edge;
   logic [7:0] raw_src;
   logic [7:0] gated_src;
   logic [7:0] source_flags_next;
   logic wake_request_next;
   logic sleep_wake_irq_enable;
   logic transient_irq_enable;
   logic orientation_irq_enable;
   logic pulse_irq_enable;
   logic fall_motion_irq_enable;
   logic sample_ready_irq_enable;

   always_comb
   begin
      sleeping_next = sleeping;
      // both directions of the rate change raise the event
      sleep_edge = sleeping ^ sleeping_reg;
      sleep_wake_irq_enable = interrupt_enable_reg[`SRC_SLEEP_BIT];
      transient_irq_enable = interrupt_enable_reg[`SRC_TRANSIENT_BIT];
      orientation_irq_enable = interrupt_enable_reg[`SRC_ORIENT_BIT];
      pulse_irq_enable = interrupt_enable_reg[`SRC_PULSE_BIT];
      fall_motion_irq_enable = interrupt_enable_reg[`SRC_FALL_BIT];
      sample_ready_irq_enable = interrupt_enable_reg[`SRC_READY_BIT];
      raw_src = 8'h00;
      raw_src[`SRC_SLEEP_BIT] = sleep_edge;
      raw_src[`SRC_TRANSIENT_BIT] = transient_evt;
      raw_src[`SRC_ORIENT_BIT] = orientation_evt;
      raw_src[`SRC_PULSE_BIT] = pulse_evt;
      raw_src[`SRC_FALL_BIT] = fall_motion_evt;
      raw_src[`SRC_READY_BIT] = sample_ready_evt;
      gated_src = 8'h00;
      gated_src[`SRC_SLEEP_BIT] = raw_src[`SRC_SLEEP_BIT] & sleep_wake_irq_enable;
      gated_src[`SRC_TRANSIENT_BIT] = raw_src[`SRC_TRANSIENT_BIT] & transient_irq_enable;
      gated_src[`SRC_ORIENT_BIT] = raw_src[`SRC_ORIENT_BIT] & orientation_irq_enable;
      gated_src[`SRC_PULSE_BIT] = raw_src[`SRC_PULSE_BIT] & pulse_irq_enable;
      gated_src[`SRC_FALL_BIT] = raw_src[`SRC_FALL_BIT] & fall_motion_irq_enable;
      gated_src[`SRC_READY_BIT] = raw_src[`SRC_READY_BIT] & sample_ready_irq_enable;
      source_flags_next = gated_src;
      // only functions allowed to wake count while asleep; others are bypassed
      wake_request_next = sleeping && (
         (gated_src[`SRC_TRANSIENT_BIT]
            && wake_source_and_pin_config_reg[`WAKE_TRANSIENT_BIT])
         || (gated_src[`SRC_ORIENT_BIT]
            && wake_source_and_pin_config_reg[`WAKE_ORIENT_BIT])
         || (gated_src[`SRC_PULSE_BIT]
            && wake_source_and_pin_config_reg[`WAKE_PULSE_BIT])
         || (gated_src[`SRC_FALL_BIT]
            && wake_source_and_pin_config_reg[`WAKE_FALL_BIT]));
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         sleeping_reg <= 1'b0;
         source_flags <= `CFG_RESET;
         wake_request <= 1'b0;
      end
      else
      begin
         sleeping_reg <= sleeping_next;
         source_flags <= source_flags_next;
         wake_request <= wake_request_next;
      end
   end

   // ----------------------------------------
   // pads
   // ----------------------------------------
   irq_pin_driver #(.WIDTH(8)) u_pin_one
   (
      .clk(clk),
      .srst(srst),
      .gated_src(gated_src),
      .route_sel(interrupt_pin_routing_reg),
      .polarity(wake_source_and_pin_config_reg[`IRQ_POLARITY_BIT]),
      .open_drain(wake_source_and_pin_config_reg[`IRQ_DRIVE_BIT]),
      .pin_o(irq_pin_one_o),
      .pin_oe_n(irq_pin_one_oe_n)
   );

   irq_pin_driver #(.WIDTH(8)) u_pin_two
   (
      .clk(clk),
      .srst(srst),
      .gated_src(gated_src),
      .route_sel(~interrupt_pin_routing_reg),
      .polarity(wake_source_and_pin_config_reg[`IRQ_POLARITY_BIT]),
      .open_drain(wake_source_and_pin_config_reg[`IRQ_DRIVE_BIT]),
      .pin_o(irq_pin_two_o),
      .pin_oe_n(irq_pin_two_oe_n)
   );
endmodule // sensor_interrupt_router

// >>> include/irq_router_regs.svh
// register offsets, field positions and reset values of the interrupt router
`ifndef IRQ_ROUTER_REGS_SVH
`define IRQ_ROUTER_REGS_SVH

// ----------------------------------------
// register indices (printed offsets) and byte addresses
// ----------------------------------------
`define WAKE_CFG_IDX 8'h2C
`define IRQ_ENABLE_IDX 8'h2D
`define IRQ_ROUTE_IDX 8'h2E
`define SRC_STATUS_IDX 8'h0C
`define IDX_TO_ADDR(i) ({2'h0, (i), 2'h0})

// ----------------------------------------
// wake_source_and_pin_config fields
// ----------------------------------------
`define WAKE_TRANSIENT_BIT 6
`define WAKE_ORIENT_BIT 5
`define WAKE_PULSE_BIT 4
`define WAKE_FALL_BIT 3
`define IRQ_POLARITY_BIT 1
`define IRQ_DRIVE_BIT 0
`define WAKE_CFG_MASK 8'h7B

// ----------------------------------------
// enable and routing fields (same positions in both)
// ----------------------------------------
`define SRC_SLEEP_BIT 7
`define SRC_TRANSIENT_BIT 5
`define SRC_ORIENT_BIT 4
`define SRC_PULSE_BIT 3
`define SRC_FALL_BIT 2
`define SRC_READY_BIT 0
`define SRC_MASK 8'hBD

// ----------------------------------------
// reset values
// ----------------------------------------
`define CFG_RESET 8'h00
`define PRDATA_ZERO 32'h0000_0000

`endif

// >>> include/irq_router_pkg.sv
// shared types of the interrupt router
package irq_router_pkg;
   typedef logic [7:0] reg8_t;
   typedef enum logic [2:0]
   {
      APB_IDLE = 3'b001,
      APB_SETUP = 3'b010,
      APB_ACCESS = 3'b100
   } apb_phase_e;
endpackage

// >>> hdl/irq_pin_driver.sv
// one interrupt pad: or of routed sources, polarity and drive type
`timescale 1ns/1ps
`include "irq_router_regs.svh"

module irq_pin_driver
   import irq_router_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [WIDTH-1:0] gated_src,
   input wire logic [WIDTH-1:0] route_sel,
   input wire logic polarity,
   input wire logic open_drain,
   output logic pin_o,
   output logic pin_oe_n
);
   logic active;
   logic pin_o_next;
   logic pin_oe_n_next;

   always_comb
   begin
      active = |(gated_src & route_sel);
      pin_o_next = polarity ? active : ~active;
      if (open_drain)
      begin
         // open drain only ever pulls to the asserted level; released otherwise
         pin_oe_n_next = ~active;
      end
      else
      begin
         pin_oe_n_next = 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         pin_o <= 1'b1;
         pin_oe_n <= 1'b0;
      end
      else
      begin
         pin_o <= pin_o_next;
         pin_oe_n <= pin_oe_n_next;
      end
   end
endmodule // irq_pin_driver

// >>> verif/irq_host_model.sv
// host side of the interrupt pads: pulled-up lines
`timescale 1ns/1ps
module irq_host_model
(
   input wire logic one_o,
   input wire logic one_oe_n,
   input wire logic two_o,
   input wire logic two_oe_n,
   output logic line_one,
   output logic line_two
);
   // released pad reads the pull-up, never the last driven level
   assign line_one = one_oe_n ? 1'b1 : one_o;
   assign line_two = two_oe_n ? 1'b1 : two_o;
endmodule // irq_host_model

// >>> verif/sensor_interrupt_router_props.sv
// port checker for the interrupt router
`timescale 1ns/1ps
module sensor_interrupt_router_props
(
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sleeping,
   input wire logic wake_request,
   input wire logic transient_evt,
   input wire logic orientation_evt,
   input wire logic pulse_evt,
   input wire logic fall_motion_evt,
   input wire logic sample_ready_evt,
   input wire logic irq_pin_one_o,
   input wire logic irq_pin_one_oe_n,
   input wire logic irq_pin_two_o,
   input wire logic irq_pin_two_oe_n,
   input wire logic [31:0] prdata,
   input wire logic [7:0] source_flags
);
   logic [7:0] ev_vec;
   assign ev_vec = {2'b00, transient_evt, orientation_evt, pulse_evt, fall_motion_evt,
      1'b0, sample_ready_evt};
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   chk_reset_idle:
      assert property ($fell(srst) |-> irq_pin_one_o && irq_pin_two_o && !irq_pin_one_oe_n
         && !irq_pin_two_oe_n && source_flags == 8'h00) else $error("pads busy after reset");
   chk_ready_pulse:
      assert property (pready |=> !pready) else $error("ready longer than one cycle");
   chk_access_answer:
      assert property (psel && penable && !pready |=> pready) else $error("no answer");
   chk_err_ready:
      assert property (pslverr |-> pready) else $error("error without ready");
   chk_upper_zero:
      assert property (pready |-> prdata[31:8] == 24'h00_0000) else $error("upper read bits");
   chk_flag_cause:
      assert property ((source_flags & 8'h3D & ~$past(ev_vec)) == 8'h00)
      else $error("flag without event");
   chk_idle_match:
      assert property (source_flags == 8'h00 |-> irq_pin_one_o == irq_pin_two_o
         && irq_pin_one_oe_n == irq_pin_two_oe_n) else $error("pad active without flag");
   chk_wake_cause:
      assert property (wake_request |-> $past(sleeping) && $past(ev_vec[5:2]) != 4'h0)
      else $error("wake without cause");
   chk_sleep_pulse:
      assert property (source_flags[7] |=> !source_flags[7]) else $error("long sleep flag");
endmodule // sensor_interrupt_router_props
bind sensor_interrupt_router sensor_interrupt_router_props chk (.clk, .srst, .psel, .penable,
   .pready, .pslverr, .sleeping, .wake_request, .transient_evt, .orientation_evt, .pulse_evt,
   .fall_motion_evt, .sample_ready_evt, .irq_pin_one_o, .irq_pin_one_oe_n, .irq_pin_two_o,
   .irq_pin_two_oe_n, .prdata, .source_flags);

// >>> verif/sensor_interrupt_router_tb_top.sv
// self-checking bench for the interrupt router
`timescale 1ns/1ps
`define CMP(n, e, s) begin n_compared++; if ((s) !== (e)) begin err_total++; \
   $display("[ERR] %s exp %h got %h", n, e, s); end end
module sensor_interrupt_router_tb_top;
   logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, sleeping = 0, r, p;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic [7:0] ev = 0, source_flags;
   logic pready, pslverr, wake_request, line_one, line_two, one_o, one_oe_n, two_o, two_oe_n;
   logic [33:0] expq[$];
   logic [33:0] e;
   logic [2:0] n_low;
   int err_total = 0, n_compared = 0;
   int src[5] = '{5, 4, 3, 2, 0};
   always #10 clk = ~clk;
   sensor_interrupt_router uut (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .sleeping, .transient_evt(ev[5]), .orientation_evt(ev[4]),
      .pulse_evt(ev[3]), .fall_motion_evt(ev[2]), .sample_ready_evt(ev[0]),
      .irq_pin_one_i(line_one), .irq_pin_two_i(line_two), .irq_pin_one_o(one_o),
      .irq_pin_one_oe_n(one_oe_n), .irq_pin_two_o(two_o), .irq_pin_two_oe_n(two_oe_n),
      .wake_request, .source_flags);
   irq_host_model host (.one_o, .one_oe_n, .two_o, .two_oe_n, .line_one, .line_two);
   task automatic end_sim();
      if (err_total == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // x holds {slverr, read data}; idle edge after release avoids a same-step re-raise
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [32:0] x);
      expq.push_back({~w, x});
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      // only the watchdog ends a wait for the answer
      do
      begin
         @(posedge clk);
      end
      while (!pready);
      psel <= 0;
      penable <= 0;
      @(posedge clk);
   endtask
   task automatic pins(input logic a1, input logic a2);
      repeat (2) @(posedge clk);
      `CMP("line_one", a1 ? p : ~p, line_one)
      `CMP("line_two", a2 ? p : ~p, line_two)
   endtask
   always @(posedge clk)
      if (pready)
      begin
         e = expq.pop_front();
         `CMP("pslverr", e[32], pslverr)
         if (e[33])
            `CMP("prdata", e[31:0], prdata)
      end
   initial
   begin
      void'($urandom(32'hd91d_4357));
      repeat (3) @(posedge clk);
      srst <= 0;
      p = 0;
      pins(0, 0);
      for (int i = 0; i < 3; i++)
      begin
         apb(0, 12'h0B0 + 12'(4 * i), 0, 0);
         apb(1, 12'h0B0 + 12'(4 * i), '1, 0);
         apb(0, 12'h0B0 + 12'(4 * i), 0, {25'h0, i == 0 ? 8'h7B : 8'hBD});
      end
      apb(0, 12'h0FC, 0, 33'h1_0000_0000);
      apb(1, 12'h030, '1, 33'h1_0000_0000);
      foreach (src[k])
      begin
         r = 1'($urandom);
         p = 1'($urandom);
         apb(1, 12'h0B0, {30'h0, p, 1'b0}, 0);
         apb(1, 12'h0B4, 32'h0000_0001 << src[k], 0);
         apb(1, 12'h0B8, 32'(r) << src[k], 0);
         ev <= 8'h01 << src[k];
         pins(r, ~r);
         apb(0, 12'h030, 0, {1'b0, 32'h0000_0001 << src[k]});
         apb(1, 12'h0B4, 0, 0);
         pins(0, 0);
         ev <= 0;
      end
      p = 0;
      apb(1, 12'h0B0, 32'h0000_0001, 0);
      apb(1, 12'h0B4, 32'h0000_00BD, 0);
      apb(1, 12'h0B8, 32'h0000_0009, 0);
      ev <= 8'h09;
      pins(1, 0);
      `CMP("oe_one", 1'b0, one_oe_n)
      ev <= 8'h01;
      pins(1, 0);
      ev <= 8'h00;
      pins(0, 0);
      `CMP("oe_one", 1'b1, one_oe_n)
      for (int j = 0; j < 2; j++)
      begin
         sleeping <= ~sleeping;
         n_low = 0;
         repeat (4)
         begin
            @(posedge clk);
            n_low += 3'(!line_two);
         end
         `CMP("sleep_pulse", 3'd1, n_low)
      end
      sleeping <= 1;
      for (int k = 0; k < 4; k++)
      begin
         apb(1, 12'h0B0, 32'h0000_0040 >> k, 0);
         ev <= 8'h20 >> k;
         repeat (2) @(posedge clk);
         `CMP("wake", 1'b1, wake_request)
         ev <= 8'h20 >> ((k + 1) % 4);
         repeat (2) @(posedge clk);
         `CMP("wake", 1'b0, wake_request)
      end
      `CMP("queue", 0, expq.size())
      end_sim();
   end
   initial
   begin
      #200000;
      err_total++;
      end_sim();
   end
endmodule // sensor_interrupt_router_tb_top
